// [cad_pkg.sv]
// constants, field layout and carrier types of the advertisement and identifier registers
//
// How it works
// RULE_01 - update-type advertisement writes wait until reset, restart, power-up or link loss
// RULE_02 - advertising gigabit makes the device send the required next pages itself
// RULE_03 - software leaves next page clear unless it has its own pages
// RULE_04 - advertisement bit 13, reset 0, sets the transmitted remote fault bit
// RULE_05 - reserved bit 12 is deferred read-write storage, reset 0
// RULE_06 - bit 11, reset 0, advertises asymmetric pause when set
// RULE_07 - bit 10, reset 0, advertises MAC pause support when set
// RULE_08 - bit 9 is storage, reset 0, kept across software reset
// RULE_09 - forced 1000 without negotiation advertises only gigabit of the chosen duplex; bit 9 (T4) is still advertised from its stored value
// RULE_10 - bit 8 advertises 100BASE-TX full duplex, deferred like the others
// RULE_11 - second identifier word holds constant organisation, model and revision fields
// RULE_12 - first identifier word is a constant organisation value, untouched by resets
// RULE_13 - acknowledge bit 14 always reads 0 and ignores writes
// RULE_14 - reads return the last written value even while still pending

package cad_pkg;

  // ----------------------------------------------------------------
  // register bus geometry and map
  // ----------------------------------------------------------------
  localparam int CAD_DATA_W = 16;
  localparam int CAD_ADDR_W = 5;
  localparam logic [4:0] CAD_OFF_ID_ONE = 5'h02;
  localparam logic [4:0] CAD_OFF_ID_TWO = 5'h03;
  localparam logic [4:0] CAD_OFF_ADV = 5'h04;

  // ----------------------------------------------------------------
  // advertisement word field positions
  // ----------------------------------------------------------------
  localparam int CAD_BIT_NP = 15;
  localparam int CAD_BIT_ACK = 14;
  localparam int CAD_BIT_RF = 13;
  localparam int CAD_BIT_RES = 12;
  localparam int CAD_BIT_ASYM = 11;
  localparam int CAD_BIT_PAUSE = 10;
  localparam int CAD_BIT_T4 = 9;
  localparam int CAD_BIT_TXFD = 8;

  // ----------------------------------------------------------------
  // identifier word two field positions
  // ----------------------------------------------------------------
  localparam int CAD_ORG_LOW_LSB = 10;
  localparam int CAD_MODEL_LSB = 4;
  localparam int CAD_REV_LSB = 0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic next_page;
    logic remote_fault;
    logic reserved;
    logic asym_pause;
    logic pause;
    logic tx_fd;
  } cad_upd_type;

  typedef struct packed {
    logic sw_reset;
    logic an_restart;
    logic power_down;
    logic link_up;
    logic an_enable;
    logic force_1000;
    logic duplex_full;
    logic gig_fd_adv;
    logic gig_hd_adv;
  } cad_ctl_type;

  typedef struct packed {
    logic next_page;
    logic remote_fault;
    logic reserved;
    logic asym_pause;
    logic pause;
    logic t4;
    logic tx_fd;
    logic gig_fd;
    logic gig_hd;
    logic auto_next_page;
    logic an_forced;
  } cad_tx_adv_type;

  // ----------------------------------------------------------------
  // values after hardware reset
  // ----------------------------------------------------------------
  localparam cad_upd_type CAD_UPD_RST = 6'h01;
  localparam logic CAD_T4_RST = 1'b0;
  localparam cad_tx_adv_type CAD_TX_RST = 11'h000;

endpackage

// [cad_apply_detect.sv]
// detection of the events that apply pending advertisement writes
`timescale 1ns/1ps
`default_nettype none

module cad_apply_detect
  import cad_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire cad_ctl_type ctl_in,
  output logic apply_out
);

  logic pd_prev_r;
  logic pd_prev_nxt;
  logic link_prev_r;
  logic link_prev_nxt;

  // ----------------------------------------------------------------
  // previous levels
  // ----------------------------------------------------------------
  always_comb
  begin
    pd_prev_nxt = ctl_in.power_down;
    link_prev_nxt = ctl_in.link_up;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      pd_prev_r <= 1'b0;
      link_prev_r <= 1'b0;
    end
    else
    begin
      pd_prev_r <= pd_prev_nxt;
      link_prev_r <= link_prev_nxt;
    end
  end

  // reset, restart, power-down exit, link loss
  assign apply_out = ctl_in.sw_reset | ctl_in.an_restart |
                     (pd_prev_r & ~ctl_in.power_down) |
                     (link_prev_r & ~ctl_in.link_up); // RULE_01

endmodule
`default_nettype wire

// [cad_adv_regs.sv]
// advertisement and identifier register logic with deferred update
`timescale 1ns/1ps
`default_nettype none

module cad_adv_regs
  import cad_pkg::*;
#(
  parameter logic [15:0] ORG_ID_HIGH = 16'h2468, // arbitrary value
  parameter logic [5:0] ORG_ID_LOW = 6'h2A, // arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h15, // arbitrary value
  parameter logic [3:0] REV_NUM = 4'h3 // arbitrary value
)
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [CAD_ADDR_W-1:0] addr_in,
  input wire logic [CAD_DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire cad_ctl_type ctl_in,
  output logic [CAD_DATA_W-1:0] rd_data_out,
  output cad_tx_adv_type tx_adv_out,
  output logic pending_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [CAD_ADDR_W-1:0] a, input logic [CAD_ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  function automatic logic [CAD_DATA_W-1:0] adv_word(input cad_upd_type u, input logic t4);
    logic [CAD_DATA_W-1:0] w;
    w = '0;
    w[CAD_BIT_NP] = u.next_page;
    w[CAD_BIT_ACK] = 1'b0;
    w[CAD_BIT_RF] = u.remote_fault;
    w[CAD_BIT_RES] = u.reserved;
    w[CAD_BIT_ASYM] = u.asym_pause;
    w[CAD_BIT_PAUSE] = u.pause;
    w[CAD_BIT_T4] = t4;
    w[CAD_BIT_TXFD] = u.tx_fd;
    adv_word = w;
  endfunction

  function automatic cad_upd_type word_to_upd(input logic [CAD_DATA_W-1:0] w);
    cad_upd_type u;
    u.next_page = w[CAD_BIT_NP];
    u.remote_fault = w[CAD_BIT_RF];
    u.reserved = w[CAD_BIT_RES];
    u.asym_pause = w[CAD_BIT_ASYM];
    u.pause = w[CAD_BIT_PAUSE];
    u.tx_fd = w[CAD_BIT_TXFD];
    word_to_upd = u;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cad_upd_type shadow_r;
  cad_upd_type shadow_nxt;
  cad_upd_type active_r;
  cad_upd_type active_nxt;
  logic t4_r;
  logic t4_nxt;
  logic [CAD_DATA_W-1:0] rd_data_r;
  logic [CAD_DATA_W-1:0] rd_data_nxt;
  cad_tx_adv_type tx_adv_r;
  cad_tx_adv_type tx_adv_nxt;
  logic pending_r;
  logic pending_nxt;
  logic apply;
  logic adv_wr;
  logic forced_gig;
  logic [CAD_DATA_W-1:0] id_two_word;
  logic [CAD_DATA_W-1:0] adv_rd_word;

  // ----------------------------------------------------------------
  // apply events
  // ----------------------------------------------------------------
  cad_apply_detect u_apply
  (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ctl_in(ctl_in),
    .apply_out(apply)
  );

  assign adv_wr = wr_in & reg_hit(addr_in, CAD_OFF_ADV);
  assign forced_gig = ~ctl_in.an_enable & ctl_in.force_1000;
  assign id_two_word = {ORG_ID_LOW, MODEL_NUM, REV_NUM};
  assign adv_rd_word = adv_word(shadow_r, t4_r);

  // ----------------------------------------------------------------
  // advertisement storage
  // ----------------------------------------------------------------
  always_comb
  begin
    shadow_nxt = shadow_r;
    t4_nxt = t4_r;
    if (adv_wr)
    begin
      shadow_nxt = word_to_upd(wr_data_in); // RULE_05 RULE_13
      t4_nxt = wr_data_in[CAD_BIT_T4]; // RULE_08
    end
    active_nxt = apply ? shadow_nxt : active_r; // RULE_01
    pending_nxt = (shadow_nxt != active_nxt);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      shadow_r <= CAD_UPD_RST;
      active_r <= CAD_UPD_RST;
      t4_r <= CAD_T4_RST;
      pending_r <= 1'b0;
    end
    else
    begin
      shadow_r <= shadow_nxt;
      active_r <= active_nxt;
      t4_r <= t4_nxt;
      pending_r <= pending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data_nxt = '0;
    if (rd_in)
    begin
      case (addr_in)
        CAD_OFF_ID_ONE: rd_data_nxt = ORG_ID_HIGH; // RULE_12
        CAD_OFF_ID_TWO: rd_data_nxt = id_two_word; // RULE_11
        CAD_OFF_ADV: rd_data_nxt = adv_rd_word; // RULE_14 RULE_13
        default: rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_r <= '0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // advertised abilities
  // ----------------------------------------------------------------
  always_comb
  begin
    tx_adv_nxt = CAD_TX_RST;
    tx_adv_nxt.remote_fault = active_r.remote_fault; // RULE_04
    tx_adv_nxt.reserved = active_r.reserved; // RULE_05
    tx_adv_nxt.asym_pause = active_r.asym_pause; // RULE_06
    tx_adv_nxt.pause = active_r.pause; // RULE_07
    tx_adv_nxt.t4 = t4_r; // RULE_08
    tx_adv_nxt.an_forced = forced_gig;
    if (forced_gig)
    begin
      tx_adv_nxt.tx_fd = 1'b0; // RULE_09
      tx_adv_nxt.gig_fd = ctl_in.duplex_full; // RULE_09
      tx_adv_nxt.gig_hd = ~ctl_in.duplex_full; // RULE_09
    end
    else
    begin
      tx_adv_nxt.tx_fd = active_r.tx_fd; // RULE_10
      tx_adv_nxt.gig_fd = ctl_in.gig_fd_adv;
      tx_adv_nxt.gig_hd = ctl_in.gig_hd_adv;
    end
    tx_adv_nxt.auto_next_page = tx_adv_nxt.gig_fd | tx_adv_nxt.gig_hd; // RULE_02
    tx_adv_nxt.next_page = active_r.next_page | tx_adv_nxt.auto_next_page; // RULE_02
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      tx_adv_r <= CAD_TX_RST;
    end
    else
    begin
      tx_adv_r <= tx_adv_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign tx_adv_out = tx_adv_r;
  assign pending_out = pending_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_adv_write_quiet;
    adv_wr && !apply;
  endsequence

  sequence s_write_applied;
    adv_wr && apply;
  endsequence

  property p_hold_pending;
    s_adv_write_quiet ##1 !apply |-> active_r == $past(active_r) ##1 pending_out == (shadow_r != active_r);
  endproperty
  a_hold_pending: assert property (p_hold_pending) else $error("pending write changed active value"); // RULE_01

  property p_apply_takes;
    apply |=> active_r == $past(shadow_nxt);
  endproperty
  a_apply_takes: assert property (p_apply_takes) else $error("apply did not load pending value"); // RULE_01

  property p_pause_path;
    s_write_applied |-> ##2 (tx_adv_out.pause == $past(wr_data_in[CAD_BIT_PAUSE], 2)) &&
      (tx_adv_out.asym_pause == $past(wr_data_in[CAD_BIT_ASYM], 2));
  endproperty
  a_pause_path: assert property (p_pause_path) else $error("pause bits not advertised"); // RULE_06 RULE_07

  property p_remote_fault;
    apply |-> ##2 tx_adv_out.remote_fault == $past(shadow_nxt.remote_fault, 2);
  endproperty
  a_remote_fault: assert property (p_remote_fault) else $error("remote fault not sent"); // RULE_04

  property p_read_shadow;
    rd_in && reg_hit(addr_in, CAD_OFF_ADV) |=> rd_data_out == $past(adv_rd_word) && !rd_data_out[CAD_BIT_ACK];
  endproperty
  a_read_shadow: assert property (p_read_shadow) else $error("advertisement read wrong"); // RULE_14 RULE_13

  property p_id_two;
    rd_in && reg_hit(addr_in, CAD_OFF_ID_TWO) |=> rd_data_out == {ORG_ID_LOW, MODEL_NUM, REV_NUM};
  endproperty
  a_id_two: assert property (p_id_two) else $error("identifier two wrong"); // RULE_11

  property p_id_one;
    rd_in && reg_hit(addr_in, CAD_OFF_ID_ONE) |=> rd_data_out == ORG_ID_HIGH;
  endproperty
  a_id_one: assert property (p_id_one) else $error("identifier one wrong"); // RULE_12

  property p_forced_gig;
    forced_gig |=> !tx_adv_out.tx_fd && tx_adv_out.gig_fd == $past(ctl_in.duplex_full) &&
      tx_adv_out.gig_hd != tx_adv_out.gig_fd;
  endproperty
  a_forced_gig: assert property (p_forced_gig) else $error("forced gigabit advert wrong"); // RULE_09

  property p_auto_np;
    tx_adv_out.auto_next_page == (tx_adv_out.gig_fd || tx_adv_out.gig_hd) &&
      (!tx_adv_out.auto_next_page || tx_adv_out.next_page);
  endproperty
  a_auto_np: assert property (p_auto_np) else $error("gigabit next pages not requested"); // RULE_02

  property p_t4_retain;
    ctl_in.sw_reset && !adv_wr |=> t4_r == $past(t4_r);
  endproperty
  a_t4_retain: assert property (p_t4_retain) else $error("bit 9 lost on software reset"); // RULE_08

  property p_txfd;
    !forced_gig |=> tx_adv_out.tx_fd == $past(active_r.tx_fd);
  endproperty
  a_txfd: assert property (p_txfd) else $error("100 full duplex advert wrong"); // RULE_10

  sequence s_pd_exit;
    ctl_in.power_down ##1 !ctl_in.power_down;
  endsequence

  sequence s_link_loss;
    ctl_in.link_up ##1 !ctl_in.link_up;
  endsequence

  property p_pd_exit;
    s_pd_exit |-> apply;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down exit did not apply"); // RULE_01

  property p_link_loss;
    s_link_loss |-> apply;
  endproperty
  a_link_loss: assert property (p_link_loss) else $error("link loss did not apply"); // RULE_01

  property p_quiet_hold;
    !apply |=> active_r == $past(active_r);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("active value moved without apply"); // RULE_01

  property p_pending_set;
    s_adv_write_quiet |=> pending_out == ($past(word_to_upd(wr_data_in)) != active_r);
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending flag wrong after write"); // RULE_01

  property p_t4_now;
    adv_wr |-> ##2 tx_adv_out.t4 == $past(wr_data_in[CAD_BIT_T4], 2);
  endproperty
  a_t4_now: assert property (p_t4_now) else $error("bit 9 not advertised at once"); // RULE_08

  property p_reserved_path;
    apply |-> ##2 tx_adv_out.reserved == $past(shadow_nxt.reserved, 2);
  endproperty
  a_reserved_path: assert property (p_reserved_path) else $error("reserved bit not sent"); // RULE_05

  property p_np_merge;
    tx_adv_out.next_page == ($past(active_r.next_page) || tx_adv_out.auto_next_page);
  endproperty
  a_np_merge: assert property (p_np_merge) else $error("next page bit wrong"); // RULE_02

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the advertisement and identifier registers
`timescale 1ns/1ps
`default_nettype none

module tb
  import cad_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  localparam logic [15:0] ID_HI = 16'h1357; // arbitrary value
  localparam logic [5:0] ID_LO = 6'h0C; // arbitrary value
  localparam logic [5:0] MODEL = 6'h21; // arbitrary value
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [4:0] addr_r = 5'h00;
  logic [15:0] wd_r = 16'h0000;
  logic wr_r = 1'b0;
  logic rd_r = 1'b0;
  cad_ctl_type ctl_r = 9'h010;
  logic [15:0] rd_data_out;
  cad_tx_adv_type tx_adv_out;
  logic pending_out;
  logic [15:0] st_w;
  logic [15:0] act_w;
  logic [15:0] d;
  cad_tx_adv_type ex;
  int errors = 0;
  int n_compared = 0;

  always #2.5 ref_clk_in = ~ref_clk_in;

  cad_adv_regs #(.ORG_ID_HIGH(ID_HI), .ORG_ID_LOW(ID_LO), .MODEL_NUM(MODEL), .REV_NUM(REV)) u_cad_adv_regs (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .addr_in(addr_r),
    .wr_data_in(wd_r),
    .wr_in(wr_r),
    .rd_in(rd_r),
    .ctl_in(ctl_r),
    .rd_data_out(rd_data_out),
    .tx_adv_out(tx_adv_out),
    .pending_out(pending_out)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] dat, input logic [15:0] e);
    wr_r <= w;
    rd_r <= !w;
    addr_r <= a;
    wd_r <= dat;
    step(1);
    if (!w)
      chk("rd_data", e, rd_data_out);
  endtask

  task automatic idle();
    wr_r <= 1'b0;
    rd_r <= 1'b0;
  endtask

  function automatic cad_tx_adv_type exp_tx();
    cad_tx_adv_type e;
    logic f;
    f = !ctl_r.an_enable && ctl_r.force_1000;
    e.gig_fd = f ? ctl_r.duplex_full : ctl_r.gig_fd_adv;
    e.gig_hd = f ? !ctl_r.duplex_full : ctl_r.gig_hd_adv;
    e.auto_next_page = e.gig_fd | e.gig_hd;
    e.next_page = act_w[15] | e.auto_next_page;
    e.remote_fault = act_w[13];
    e.reserved = act_w[12];
    e.asym_pause = act_w[11];
    e.pause = act_w[10];
    e.t4 = st_w[9];
    e.tx_fd = f ? 1'b0 : act_w[8];
    e.an_forced = f;
    return e;
  endfunction

  task automatic chk_tx();
    chk("tx_adv", 16'(exp_tx()), 16'(tx_adv_out));
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(81306));
    st_w = 16'h0100;
    act_w = 16'h0100;
    step(16);
    chk("rd_data", 16'h0000, rd_data_out);
    chk("tx_adv", 16'h0000, 16'(tx_adv_out));
    chk("pending", 16'h0000, 16'(pending_out));
    rst_b_in <= 1'b1;
    step(3);
    chk_tx();
    bus(1'b0, CAD_OFF_ID_ONE, 16'h0000, ID_HI);
    bus(1'b0, CAD_OFF_ID_TWO, 16'h0000, {ID_LO, MODEL, REV});
    bus(1'b0, CAD_OFF_ADV, 16'h0000, 16'h0100);
    bus(1'b0, 5'h1F, 16'h0000, 16'h0000);
    bus(1'b1, CAD_OFF_ID_ONE, 16'(~ID_HI), 16'h0000);
    bus(1'b1, CAD_OFF_ID_TWO, 16'hFFFF, 16'h0000);
    bus(1'b0, CAD_OFF_ID_ONE, 16'h0000, ID_HI);
    bus(1'b0, CAD_OFF_ID_TWO, 16'h0000, {ID_LO, MODEL, REV});
    idle();
    step(1);
    chk("rd_data", 16'h0000, rd_data_out);
    // two pending writes per apply event kind
    for (int k = 0; k < 8; k++)
    begin
      d = 16'($urandom()) | 16'h4000;
      if (k != 7)
        d[15] = 1'b0;
      bus(1'b1, CAD_OFF_ADV, d, 16'h0000);
      st_w = d & 16'hBF00;
      bus(1'b0, CAD_OFF_ADV, 16'h0000, st_w);
      idle();
      step(3);
      chk("pending", 16'(((st_w ^ act_w) & 16'hBD00) != 16'h0000), 16'(pending_out));
      chk_tx();
      if (k % 4 == 2)
        ctl_r.power_down <= 1'b1;
      if (k % 4 == 3)
        ctl_r.link_up <= 1'b1;
      step(3);
      chk_tx();
      case (k % 4)
        0: ctl_r.sw_reset <= 1'b1;
        1: ctl_r.an_restart <= 1'b1;
        2: ctl_r.power_down <= 1'b0;
        default: ctl_r.link_up <= 1'b0;
      endcase
      step(1);
      ctl_r.sw_reset <= 1'b0;
      ctl_r.an_restart <= 1'b0;
      act_w = st_w;
      step(3);
      chk_tx();
      chk("pending", 16'h0000, 16'(pending_out));
      bus(1'b0, CAD_OFF_ADV, 16'h0000, st_w);
      idle();
      step(1);
    end
    // write landing in the same cycle as a restart
    d = 16'($urandom()) & 16'h7FFF;
    ctl_r.an_restart <= 1'b1;
    bus(1'b1, CAD_OFF_ADV, d, 16'h0000);
    ctl_r.an_restart <= 1'b0;
    st_w = d & 16'hBF00;
    act_w = st_w;
    idle();
    step(3);
    chk_tx();
    chk("pending", 16'h0000, 16'(pending_out));
    bus(1'b0, CAD_OFF_ADV, 16'h0000, st_w);
    idle();
    step(1);
    // all control mode combinations
    for (int i = 0; i < 32; i++)
    begin
      ctl_r.an_enable <= i[0];
      ctl_r.force_1000 <= i[1];
      ctl_r.duplex_full <= i[2];
      ctl_r.gig_fd_adv <= i[3];
      ctl_r.gig_hd_adv <= i[4];
      step(3);
      chk_tx();
      ex = exp_tx();
      chk("auto_np", 16'(ex.auto_next_page), 16'(tx_adv_out.auto_next_page));
    end
    // second hardware reset returns storage to its reset value
    rst_b_in <= 1'b0;
    step(2);
    rst_b_in <= 1'b1;
    st_w = 16'h0100;
    act_w = 16'h0100;
    step(3);
    bus(1'b0, CAD_OFF_ADV, 16'h0000, 16'h0100);
    idle();
    step(1);
    chk_tx();
    close_out();
  end

endmodule

`default_nettype wire
